// *** include/pwr_seq_pkg.sv ***
// constants shared by the per-channel power on/off sequencer and its register front end
// assumes one 100 MHz clock and commands already decoded from the serial bus into code, page and data
// Summary of operation
// - policy writes with page 0xff reach every channel
// - no channel starts sequencing until input voltage is above its on threshold
// - policy bits 7..5 ignore writes and read 0, bit 1 reads 1
// - gate bit clear: channel powers up alone, honouring the turn-on wait
// - gate bit set: power up only from enabled sources, never if both disabled
// - bus enable bit clear ignores the operation on/off field, set obeys it
// - pin enable bit set requires the run pin asserted, anded with bus command
// - run pin off: turn-off wait, or immediate off skipping the wait when fast bit set
// - setup bits 15 and 9..8 ignore writes and read 0
// - cascade bit makes the run pin a sequence-on input only, never an off input
// - two-bit pin select routes run pin 0..3 to the channel
// - fast servo active in margin and trim when bit 11 is 0
// - supervisor step is 4 mV when bit 10 is 0, 8 mV when 1
// - dac mode 00: continuous bit keeps servoing after target, else stops
// - mode 00, not continuous: warning hit restarts servo to nominal when enabled
// - after rise time, dac mode picks servo, open, direct connect or soft connect
// - channel on: weak pull-up if bit 3 set, else enable driver released
// - channel off: fast pull-down after a fault, otherwise weak pull-down when bit 2 set
// - operation field 00 off now, 10 sequence on, 01 sequence off with wait
package pwr_seq_pkg;
  localparam int          NUM_CH          = 4;
  localparam logic [7:0]  CMD_OPERATION   = 8'h01;
  localparam logic [7:0]  CMD_POLICY      = 8'h02;
  localparam logic [7:0]  CMD_SETUP       = 8'hd0;
  localparam logic [7:0]  PAGE_ALL        = 8'hff;
  localparam logic [7:0]  OPERATION_RST   = 8'h00;
  localparam logic [7:0]  POLICY_RST      = 8'h1e;
  localparam logic [15:0] SETUP_RST       = 16'h0080;
  localparam logic [7:0]  OPERATION_WMASK = 8'hfc;
  localparam logic [7:0]  POLICY_WMASK    = 8'h1d;
  localparam logic [7:0]  POLICY_ONES     = 8'h02;
  localparam logic [15:0] SETUP_WMASK     = 16'h7cff;
  localparam int          POL_GATE        = 4;
  localparam int          POL_BUS         = 3;
  localparam int          POL_PIN         = 2;
  localparam int          POL_FAST        = 0;
  localparam int          OP_CTRL_LO      = 6;
  localparam int          SET_CASCADE     = 14;
  localparam int          SET_PINSEL_LO   = 12;
  localparam int          SET_FSERVO_OFF  = 11;
  localparam int          SET_SUP_RES     = 10;
  localparam int          SET_SERVO_CONT  = 7;
  localparam int          SET_SERVO_WARN  = 6;
  localparam int          SET_DAC_LO      = 4;
  localparam int          SET_WPU         = 3;
  localparam int          SET_WPD         = 2;
  localparam logic [1:0]  OP_OFF_NOW      = 2'h0;
  localparam logic [1:0]  OP_SEQ_OFF      = 2'h1;
  localparam logic [1:0]  OP_SEQ_ON       = 2'h2;
  localparam logic [1:0]  DAC_SERVO       = 2'h0;
  localparam logic [1:0]  DAC_OPEN        = 2'h1;
  localparam logic [1:0]  DAC_DIRECT      = 2'h2;
  localparam logic [1:0]  DAC_SOFT        = 2'h3;
  localparam logic [3:0]  SUP_FINE_MV     = 4'h4;
  localparam logic [3:0]  SUP_COARSE_MV   = 4'h8;
  localparam int          CLK_PERIOD_NS   = 10;
  localparam int          ON_WAIT_NS      = 1000;
  localparam int          OFF_WAIT_NS     = 1000;
  localparam int          RISE_NS         = 2000;
  localparam int          ON_WAIT_CYC     = (ON_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          OFF_WAIT_CYC    = (OFF_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          RISE_CYC        = (RISE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          TIMER_W         = 16;
endpackage

// *** include/chan_ctl_if.sv ***
// request and status bundle between the front end and one channel sequencer
// assumes both ends run on sys_clk
`timescale 1ns/1ps
interface chan_ctl_if;
  logic        want_on;
  logic        off_now;
  logic        fault_off;
  logic        vin_ok;
  logic        target_reached;
  logic        warn_hit;
  logic [15:0] setup;
  logic        chan_on;
  logic        en_o;
  logic        en_oe;
  logic        en_weak;
  logic        dac_connect;
  logic        dac_soft;
  logic        servo;
  logic        fast_servo;
  logic [3:0]  sup_lsb_mv;
  modport front (output want_on, off_now, fault_off, vin_ok, target_reached, warn_hit, setup,
                 input chan_on, en_o, en_oe, en_weak, dac_connect, dac_soft, servo, fast_servo, sup_lsb_mv);
  modport chan (input want_on, off_now, fault_off, vin_ok, target_reached, warn_hit, setup,
                output chan_on, en_o, en_oe, en_weak, dac_connect, dac_soft, servo, fast_servo, sup_lsb_mv);
endinterface

// *** design/pin_sync.sv ***
// two-stage synchroniser for a group of asynchronous level inputs
// assumes inputs are slow levels; pulses shorter than one clock may be lost
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 5
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  initial if (WIDTH < 1) $error("pin_sync width must be positive");
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    logic meta_reg;
    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        meta_reg    <= 1'b0;
        sync_out[i] <= 1'b0;
      end else begin
        meta_reg    <= async_in[i];
        sync_out[i] <= meta_reg;
      end
    end
  end
endmodule // pin_sync

// *** design/channel_seq.sv ***
// one channel: on/off state machine, enable pin drive and trim dac connection
// assumes requests from the front end are on sys_clk and setup is held steady
`timescale 1ns/1ps
module channel_seq #(
  parameter int ON_CYC   = pwr_seq_pkg::ON_WAIT_CYC,
  parameter int OFF_CYC  = pwr_seq_pkg::OFF_WAIT_CYC,
  parameter int RISE_CYC = pwr_seq_pkg::RISE_CYC
) (
  input  wire logic   sys_clk,
  input  wire logic   rst_n,
  chan_ctl_if.chan    ctl
);
  localparam logic [pwr_seq_pkg::TIMER_W-1:0] ON_T   = pwr_seq_pkg::TIMER_W'(ON_CYC - 1);
  localparam logic [pwr_seq_pkg::TIMER_W-1:0] OFF_T  = pwr_seq_pkg::TIMER_W'(OFF_CYC - 1);
  localparam logic [pwr_seq_pkg::TIMER_W-1:0] RISE_T = pwr_seq_pkg::TIMER_W'(RISE_CYC - 1);
  initial if (ON_CYC < 1 || OFF_CYC < 1 || RISE_CYC < 1 || RISE_CYC > 65536 || ON_CYC > 65536 || OFF_CYC > 65536)
    $error("channel_seq wait counts out of range");

  typedef enum logic [2:0] {ST_OFF, ST_ON_WAIT, ST_RISE, ST_ON, ST_OFF_WAIT} chan_state_t;
  chan_state_t state_reg, state_next;
  logic [pwr_seq_pkg::TIMER_W-1:0] timer_reg, timer_next;
  logic fault_reg, reached_reg;

  wire       timer_done = (timer_reg == '0);
  wire       is_on      = (state_reg == ST_RISE) || (state_reg == ST_ON) || (state_reg == ST_OFF_WAIT);
  wire [1:0] dac_mode   = ctl.setup[pwr_seq_pkg::SET_DAC_LO +: 2];
  wire       servo_cont = ctl.setup[pwr_seq_pkg::SET_SERVO_CONT];
  wire       rewarn     = ctl.warn_hit && ctl.setup[pwr_seq_pkg::SET_SERVO_WARN] && !servo_cont;
  wire       in_target  = (state_reg == ST_ON);

  always_comb begin
    state_next = state_reg;
    timer_next = timer_done ? timer_reg : timer_reg - 1'b1;
    case (state_reg)
      ST_OFF: if (ctl.want_on && ctl.vin_ok && !ctl.fault_off) begin
        state_next = ST_ON_WAIT;
        timer_next = ON_T;
      end
      ST_ON_WAIT: if (ctl.fault_off || !ctl.want_on || ctl.off_now) begin
        state_next = ST_OFF;
      end else if (timer_done) begin
        state_next = ST_RISE;
        timer_next = RISE_T;
      end
      ST_RISE, ST_ON: if (ctl.fault_off || ctl.off_now) begin
        state_next = ST_OFF;
      end else if (!ctl.want_on) begin
        state_next = ST_OFF_WAIT;
        timer_next = OFF_T;
      end else if (state_reg == ST_RISE && timer_done) begin
        state_next = ST_ON;
      end
      ST_OFF_WAIT: if (ctl.fault_off || ctl.off_now || timer_done) begin
        state_next = ST_OFF;
      end else if (ctl.want_on) begin
        state_next = ST_ON;
      end
      default: state_next = ST_OFF;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg   <= ST_OFF;
      timer_reg   <= '0;
      fault_reg   <= 1'b0;
      reached_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      timer_reg <= timer_next;
      if (ctl.fault_off && state_reg != ST_OFF)
        fault_reg <= 1'b1;
      else if (state_next == ST_ON_WAIT)
        fault_reg <= 1'b0;
      // a warning in the same cycle as the target wins, so servo restarts
      if (!in_target || rewarn)
        reached_reg <= 1'b0;
      else if (ctl.target_reached)
        reached_reg <= 1'b1;
    end
  end

  // pin drive: on releases or weakly pulls up, off pulls down hard unless bit 2 is set and the stop was not a fault
  wire wpu      = ctl.setup[pwr_seq_pkg::SET_WPU];
  wire wpd      = ctl.setup[pwr_seq_pkg::SET_WPD];
  wire servo_nx = in_target && dac_mode == pwr_seq_pkg::DAC_SERVO && (servo_cont || !reached_reg);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl.chan_on     <= 1'b0;
      ctl.en_o        <= 1'b0;
      ctl.en_oe       <= 1'b1;
      ctl.en_weak     <= 1'b0;
      ctl.dac_connect <= 1'b0;
      ctl.dac_soft    <= 1'b0;
      ctl.servo       <= 1'b0;
      ctl.fast_servo  <= 1'b0;
      ctl.sup_lsb_mv  <= pwr_seq_pkg::SUP_FINE_MV;
    end else begin
      ctl.chan_on     <= is_on;
      ctl.en_o        <= is_on;
      ctl.en_oe       <= is_on ? wpu : 1'b1;
      ctl.en_weak     <= is_on ? wpu : (wpd && !fault_reg);
      ctl.dac_connect <= in_target && dac_mode != pwr_seq_pkg::DAC_OPEN;
      ctl.dac_soft    <= in_target && (dac_mode == pwr_seq_pkg::DAC_SERVO || dac_mode == pwr_seq_pkg::DAC_SOFT);
      ctl.servo       <= servo_nx;
      ctl.fast_servo  <= servo_nx && !ctl.setup[pwr_seq_pkg::SET_FSERVO_OFF];
      ctl.sup_lsb_mv  <= ctl.setup[pwr_seq_pkg::SET_SUP_RES] ? pwr_seq_pkg::SUP_COARSE_MV
                                                              : pwr_seq_pkg::SUP_FINE_MV;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_vin_holds_start: assert property (state_reg == ST_OFF && !ctl.vin_ok |=> state_reg == ST_OFF)
    else $error("channel left off while input below threshold");
  a_on_wait_ends: assert property (state_reg == ST_ON_WAIT && timer_done && ctl.want_on && !ctl.fault_off
                                   && !ctl.off_now |=> state_reg == ST_RISE)
    else $error("turn-on wait did not lead to rise");
  a_off_now_fast: assert property (is_on && ctl.off_now |=> state_reg == ST_OFF ##1 ctl.en_oe && !ctl.en_o)
    else $error("immediate off not taken");
  a_soft_off_wait: assert property (is_on && state_reg != ST_OFF_WAIT && !ctl.want_on && !ctl.off_now
                                    && !ctl.fault_off |=> state_reg == ST_OFF_WAIT && timer_reg == OFF_T)
    else $error("sequenced off skipped the turn-off wait");
  a_fault_fast_pd: assert property (state_reg == ST_OFF && fault_reg |=> ctl.en_oe && !ctl.en_weak)
    else $error("fault off did not use fast pull-down");
  a_on_release: assert property (is_on && !wpu |=> !ctl.en_oe)
    else $error("enable driver not released while on");
  a_dac_open: assert property (dac_mode == pwr_seq_pkg::DAC_OPEN |=> !ctl.dac_connect && !ctl.servo)
    else $error("dac connected in open mode");
  a_servo_stops: assert property (in_target && reached_reg && !servo_cont && !rewarn && $stable(state_reg)
                                  |=> !ctl.servo)
    else $error("servo continued after target");
  c_reach_on: cover property (state_reg == ST_RISE ##1 state_reg == ST_ON);
  c_fault_off: cover property (state_reg == ST_ON && ctl.fault_off ##1 state_reg == ST_OFF);
  c_timed_off: cover property (state_reg == ST_OFF_WAIT && timer_done ##1 state_reg == ST_OFF);
endmodule // channel_seq

// *** design/power_onoff_ctrl.sv ***
// four-channel on/off control: command registers, run pin routing and channel sequencers
// assumes commands arrive already decoded from the serial bus, one per cycle, on sys_clk;
// run pins and the input threshold comparator are asynchronous and are synchronised here
`timescale 1ns/1ps
module power_onoff_ctrl #(
  parameter int ON_CYC   = pwr_seq_pkg::ON_WAIT_CYC,
  parameter int OFF_CYC  = pwr_seq_pkg::OFF_WAIT_CYC,
  parameter int RISE_CYC = pwr_seq_pkg::RISE_CYC
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        cmd_valid,
  input  wire logic        cmd_write,
  input  wire logic [7:0]  cmd_code,
  input  wire logic [7:0]  cmd_page,
  input  wire logic [15:0] cmd_wdata,
  output logic             rd_valid,
  output logic      [15:0] rd_data,
  input  wire logic [3:0]  run_pin,
  input  wire logic        vin_above_on,
  input  wire logic [3:0]  chan_fault,
  input  wire logic [3:0]  target_reached,
  input  wire logic [3:0]  warn_hit,
  output logic      [3:0]  chan_on,
  output logic      [3:0]  out_en_o,
  output logic      [3:0]  out_en_oe,
  output logic      [3:0]  out_en_weak,
  output logic      [3:0]  dac_connect,
  output logic      [3:0]  dac_soft,
  output logic      [3:0]  servo_active,
  output logic      [3:0]  fast_servo,
  output logic      [15:0] sup_lsb_mv
);
  localparam int N = pwr_seq_pkg::NUM_CH;

  // synchronised run pins in bits 3..0, input threshold comparator in bit 4
  logic [N:0] pins_sync;
  pin_sync #(.WIDTH(N + 1)) u_pin_sync (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .async_in ({vin_above_on, run_pin}),
    .sync_out (pins_sync)
  );
  wire vin_ok = pins_sync[N];

  wire       wr_en      = cmd_valid && cmd_write;
  wire       page_all   = (cmd_page == pwr_seq_pkg::PAGE_ALL);
  wire       page_known = page_all || (cmd_page < 8'(N));
  wire [1:0] rd_ch      = page_all ? 2'h0 : cmd_page[1:0];
  wire       wr_op      = wr_en && cmd_code == pwr_seq_pkg::CMD_OPERATION;
  wire       wr_policy  = wr_en && cmd_code == pwr_seq_pkg::CMD_POLICY;
  wire       wr_setup   = wr_en && cmd_code == pwr_seq_pkg::CMD_SETUP;

  logic [7:0]  op_reg     [N];
  logic [7:0]  policy_reg [N];
  logic [15:0] setup_reg  [N];
  chan_ctl_if ctl [N] ();

  for (genvar g = 0; g < N; g++) begin : g_ch
    wire hit = page_all || cmd_page == 8'(g);
    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        op_reg[g]     <= pwr_seq_pkg::OPERATION_RST;
        policy_reg[g] <= pwr_seq_pkg::POLICY_RST;
        setup_reg[g]  <= pwr_seq_pkg::SETUP_RST;
      end else begin
        if (wr_op && hit)
          op_reg[g] <= cmd_wdata[7:0] & pwr_seq_pkg::OPERATION_WMASK;
        if (wr_policy && hit)
          policy_reg[g] <= (cmd_wdata[7:0] & pwr_seq_pkg::POLICY_WMASK) | pwr_seq_pkg::POLICY_ONES;
        if (wr_setup && hit)
          setup_reg[g] <= cmd_wdata & pwr_seq_pkg::SETUP_WMASK;
      end
    end

    // on/off decision from the policy byte, the selected run pin and the operation field
    wire [1:0] op_ctrl  = op_reg[g][pwr_seq_pkg::OP_CTRL_LO +: 2];
    wire       gate     = policy_reg[g][pwr_seq_pkg::POL_GATE];
    wire       use_bus  = policy_reg[g][pwr_seq_pkg::POL_BUS];
    wire       use_pin  = policy_reg[g][pwr_seq_pkg::POL_PIN];
    wire       fast_off = policy_reg[g][pwr_seq_pkg::POL_FAST];
    wire       cascade  = setup_reg[g][pwr_seq_pkg::SET_CASCADE];
    wire       pin_raw  = pins_sync[setup_reg[g][pwr_seq_pkg::SET_PINSEL_LO +: 2]];
    // cascade: a low pin never takes a running channel down, off comes from bus or fault only
    wire       pin_ok   = pin_raw || (cascade && ctl[g].chan_on);
    wire       bus_on   = (op_ctrl == pwr_seq_pkg::OP_SEQ_ON);
    wire       want_on  = !gate || ((use_bus || use_pin) && (!use_bus || bus_on) && (!use_pin || pin_ok));
    wire       bus_kill = gate && use_bus && op_ctrl == pwr_seq_pkg::OP_OFF_NOW;
    wire       pin_kill = gate && use_pin && fast_off && !pin_ok;

    assign ctl[g].want_on        = want_on;
    assign ctl[g].off_now        = bus_kill || pin_kill;
    assign ctl[g].fault_off      = chan_fault[g];
    assign ctl[g].vin_ok         = vin_ok;
    assign ctl[g].target_reached = target_reached[g];
    assign ctl[g].warn_hit       = warn_hit[g];
    assign ctl[g].setup          = setup_reg[g];

    channel_seq #(
      .ON_CYC   (ON_CYC),
      .OFF_CYC  (OFF_CYC),
      .RISE_CYC (RISE_CYC)
    ) u_chan (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .ctl     (ctl[g])
    );

    assign chan_on[g]             = ctl[g].chan_on;
    assign out_en_o[g]            = ctl[g].en_o;
    assign out_en_oe[g]           = ctl[g].en_oe;
    assign out_en_weak[g]         = ctl[g].en_weak;
    assign dac_connect[g]         = ctl[g].dac_connect;
    assign dac_soft[g]            = ctl[g].dac_soft;
    assign servo_active[g]        = ctl[g].servo;
    assign fast_servo[g]          = ctl[g].fast_servo;
    assign sup_lsb_mv[4*g +: 4]   = ctl[g].sup_lsb_mv;

    a_gate_never_on: assert property (@(posedge sys_clk) disable iff (!rst_n)
      gate && !use_bus && !use_pin |-> !want_on)
      else $error("channel requested on with both sources disabled");
    a_gate_clear_on: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !gate |-> want_on && !(bus_kill || pin_kill))
      else $error("ungated channel not requested on");
    a_bus_ignored: assert property (@(posedge sys_clk) disable iff (!rst_n)
      gate && !use_bus && use_pin |-> want_on == pin_ok)
      else $error("operation field acted on with bus control off");
  end

  // reads answer one cycle later; unknown codes or pages read zero
  wire [15:0] rd_mux =
    !page_known                              ? 16'h0000 :
    cmd_code == pwr_seq_pkg::CMD_OPERATION   ? {8'h00, op_reg[rd_ch]} :
    cmd_code == pwr_seq_pkg::CMD_POLICY      ? {8'h00, policy_reg[rd_ch]} :
    cmd_code == pwr_seq_pkg::CMD_SETUP       ? setup_reg[rd_ch] : 16'h0000;
  wire rd_req = cmd_valid && !cmd_write;
  logic rd_policy_reg;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_valid      <= 1'b0;
      rd_data       <= 16'h0000;
      rd_policy_reg <= 1'b0;
    end else begin
      rd_valid      <= rd_req;
      rd_policy_reg <= rd_req && page_known && cmd_code == pwr_seq_pkg::CMD_POLICY;
      if (rd_req)
        rd_data <= rd_mux;
    end
  end

  a_global_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wr_policy && page_all |=> policy_reg[0] == policy_reg[3] && policy_reg[1] == policy_reg[2]
                              && policy_reg[0] == policy_reg[1])
    else $error("global policy write missed a channel");
  a_policy_fixed: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rd_valid && rd_policy_reg |-> rd_data[7:5] == 3'h0 && rd_data[1])
    else $error("policy reserved bits read wrong");
  a_setup_rsvd: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rd_valid |-> !rd_data[15] && rd_data[9:8] == 2'h0)
    else $error("setup reserved bits read non-zero");
  c_global_write: cover property (@(posedge sys_clk) disable iff (!rst_n) wr_policy && page_all);
  c_all_on: cover property (@(posedge sys_clk) disable iff (!rst_n) chan_on == 4'hf);
endmodule // power_onoff_ctrl

// *** verif/supply_model.sv ***
// four dc/dc supplies behind the trim outputs: target reached two cycles into a servo run
// assumes servo flags on sys_clk; over/under warnings are requested by the bench
`timescale 1ns/1ps
module supply_model (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic [3:0] servo_active,
  input  wire logic [3:0] warn_req,
  output logic      [3:0] target_reached,
  output logic      [3:0] warn_hit
);
  logic [3:0] settle_reg;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      settle_reg     <= 4'h0;
      target_reached <= 4'h0;
      warn_hit       <= 4'h0;
    end else begin
      settle_reg     <= servo_active;
      target_reached <= settle_reg & servo_active;
      warn_hit       <= warn_req;
    end
  end
endmodule // supply_model

// *** verif/channel_onoff_config_bench.sv ***
// bench for the four-channel on/off controller: registers, start sources, stop paths, pin drive
// assumes short wait parameters (on 3, off 20, rise 3) so fast and timed stops differ clearly
`timescale 1ns/1ps
module channel_onoff_config_bench;
  logic        sys_clk, rst_n, cmd_valid, cmd_write, vin_above_on, rd_valid;
  logic [7:0]  cmd_code, cmd_page;
  logic [15:0] cmd_wdata, rd_data, sup_lsb_mv, d;
  logic [3:0]  run_pin, chan_fault, target_reached, warn_hit, warn_req, chan_on, out_en_o, out_en_oe;
  logic [3:0]  out_en_weak, dac_connect, dac_soft, servo_active, fast_servo;
  logic [15:0] exp_q[$];
  int          fail_count, compares, seed;
  power_onoff_ctrl #(.ON_CYC(3), .OFF_CYC(20), .RISE_CYC(3)) u_dut (.sys_clk, .rst_n, .cmd_valid,
    .cmd_write, .cmd_code, .cmd_page, .cmd_wdata, .rd_valid, .rd_data, .run_pin, .vin_above_on,
    .chan_fault, .target_reached, .warn_hit, .chan_on, .out_en_o, .out_en_oe, .out_en_weak,
    .dac_connect, .dac_soft, .servo_active, .fast_servo, .sup_lsb_mv);
  supply_model u_sup (.sys_clk, .rst_n, .servo_active, .warn_req, .target_reached, .warn_hit);
  initial begin
    sys_clk = 1'h0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic end_of_test;
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic hold(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic cmd(input logic wr, input logic [7:0] code, page, input logic [15:0] data);
    hold(1);
    cmd_valid = 1'h1;
    cmd_write = wr;
    cmd_code = code;
    cmd_page = page;
    cmd_wdata = data;
    hold(1);
    cmd_valid = 1'h0;
  endtask
  task automatic rd(input logic [7:0] code, page, input logic [15:0] exp);
    exp_q.push_back(exp);
    cmd(1'h0, code, page, 16'h0000);
  endtask
  // bounded wait for the channel-on pattern; running out ends the run
  task automatic wait_on(input logic [3:0] mask, input int lim);
    int n;
    n = 0;
    while (chan_on !== mask && n < lim) begin
      hold(1);
      n++;
    end
    check({12'h000, chan_on}, {12'h000, mask});
    if (chan_on !== mask) end_of_test();
  endtask
  always @(posedge sys_clk) begin
    if (rd_valid === 1'h1) begin
      // an answer nobody asked for is a mismatch even when the data is unknown
      if (exp_q.size() == 0) check(16'h0001, 16'h0000);
      else check(rd_data, exp_q.pop_front());
    end
  end
  initial begin
    seed = 32'hf3cc2aaa;
    {rst_n, cmd_valid, cmd_write, cmd_code, cmd_page, cmd_wdata} = '0;
    {run_pin, vin_above_on, chan_fault, warn_req, fail_count, compares} = '0;
    hold(12);
    rst_n = 1'h1;
    rd(pwr_seq_pkg::CMD_POLICY, 8'h00, 16'h001e);
    rd(pwr_seq_pkg::CMD_SETUP, 8'h03, 16'h0080);
    cmd(1'h1, pwr_seq_pkg::CMD_POLICY, 8'hff, 16'h00ff);
    for (int g = 0; g < 4; g++) rd(pwr_seq_pkg::CMD_POLICY, g[7:0], 16'h001f);
    for (int g = 0; g < 4; g++) begin
      d = 16'($random(seed));
      cmd(1'h1, pwr_seq_pkg::CMD_SETUP, g[7:0], d);
      rd(pwr_seq_pkg::CMD_SETUP, g[7:0], d & 16'h7cff);
    end
    rd(pwr_seq_pkg::CMD_POLICY, 8'h07, 16'h0000);
    $display("register test done");
    cmd(1'h1, pwr_seq_pkg::CMD_SETUP, 8'hff, 16'h0008);
    cmd(1'h1, pwr_seq_pkg::CMD_POLICY, 8'hff, 16'h0002);
    hold(30);
    wait_on(4'h0, 1);
    vin_above_on = 1'h1;
    warn_req = 4'($random(seed));
    wait_on(4'hf, 40);
    check({out_en_o, out_en_oe, out_en_weak, sup_lsb_mv[3:0]}, 16'hfff4);
    cmd(1'h1, pwr_seq_pkg::CMD_SETUP, 8'hff, 16'h0400);
    hold(3);
    check({out_en_oe, sup_lsb_mv[11:0]}, 16'h0888);
    cmd(1'h1, pwr_seq_pkg::CMD_POLICY, 8'hff, 16'h0012);
    cmd(1'h1, pwr_seq_pkg::CMD_OPERATION, 8'hff, 16'h0080);
    run_pin = 4'hf;
    wait_on(4'h0, 60);
    hold(30);
    wait_on(4'h0, 1);
    check({out_en_o, out_en_oe, out_en_weak}, 16'h00f0);
    $display("source gating test done");
    cmd(1'h1, pwr_seq_pkg::CMD_POLICY, 8'hff, 16'h001a);
    wait_on(4'hf, 40);
    cmd(1'h1, pwr_seq_pkg::CMD_OPERATION, 8'hff, 16'h0040);
    hold(10);
    wait_on(4'hf, 1);
    wait_on(4'h0, 40);
    cmd(1'h1, pwr_seq_pkg::CMD_OPERATION, 8'hff, 16'h0080);
    wait_on(4'hf, 40);
    cmd(1'h1, pwr_seq_pkg::CMD_OPERATION, 8'hff, 16'h0000);
    wait_on(4'h0, 4);
    cmd(1'h1, pwr_seq_pkg::CMD_POLICY, 8'hff, 16'h0016);
    wait_on(4'hf, 40);
    $display("bus command test done");
    for (int g = 0; g < 4; g++) cmd(1'h1, pwr_seq_pkg::CMD_SETUP, g[7:0], {2'h0, 2'(3 - g), 12'h004});
    cmd(1'h1, pwr_seq_pkg::CMD_POLICY, 8'hff, 16'h0017);
    for (int k = 0; k < 4; k++) begin
      run_pin = 4'h0;
      wait_on(4'h0, 8);
      check({12'h000, out_en_weak}, 16'h000f);
      hold(10);
      run_pin = 4'h1 << k;
      wait_on(4'h8 >> k, 40);
    end
    run_pin = 4'hf;
    wait_on(4'hf, 40);
    chan_fault = 4'h1;
    hold(4);
    // channels 1..3 stay on with the weak pull-up off; channel 0 is off with the fast pull-down
    check({8'h00, chan_on, out_en_weak}, 16'h00e0);
    chan_fault = 4'h0;
    $display("run pin test done");
    cmd(1'h1, pwr_seq_pkg::CMD_SETUP, 8'hff, 16'h4000);
    cmd(1'h1, pwr_seq_pkg::CMD_POLICY, 8'hff, 16'h0016);
    run_pin = 4'h1;
    wait_on(4'hf, 40);
    run_pin = 4'h0;
    hold(40);
    wait_on(4'hf, 1);
    $display("cascade test done");
    // cascade stays set so the low pin keeps every channel on while the dac modes change
    cmd(1'h1, pwr_seq_pkg::CMD_SETUP, 8'h00, 16'h4010);
    cmd(1'h1, pwr_seq_pkg::CMD_SETUP, 8'h01, 16'h4020); // host owns the dac code before direct mode
    cmd(1'h1, pwr_seq_pkg::CMD_SETUP, 8'h02, 16'h4030);
    cmd(1'h1, pwr_seq_pkg::CMD_SETUP, 8'h03, 16'h4080);
    hold(3);
    check({dac_connect, dac_soft, servo_active, fast_servo}, 16'hec88);
    cmd(1'h1, pwr_seq_pkg::CMD_SETUP, 8'h03, 16'h4880);
    hold(3);
    check({8'h00, servo_active, fast_servo}, 16'h0080);
    warn_req = 4'h0;
    cmd(1'h1, pwr_seq_pkg::CMD_SETUP, 8'h03, 16'h4040);
    hold(10);
    check({12'h000, servo_active}, 16'h0000);
    warn_req = 4'h8;
    hold(4);
    check({12'h000, servo_active}, 16'h0008);
    $display("dac mode test done");
    end_of_test();
  end
endmodule // channel_onoff_config_bench
